// ==== rtl/rim_pkg.sv ====
package rim_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_W = 8;
  // printed offset 0x91 is not a multiple of four: keep it as an index
  localparam logic [ADDR_W-1:0] ENABLE_IDX = 8'h91;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 8'h92;
  localparam logic [ADDR_W+1:0] ENABLE_ADDR = {ENABLE_IDX, 2'b00};
  localparam logic [ADDR_W+1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam int BIT_SFD = 0;
  localparam int BIT_CCA = 1;
  localparam int BIT_PQT = 2;
  localparam int BIT_CS = 3;
  localparam int BIT_DONE = 4;
  localparam int BIT_TIMEOUT = 5;
  // upper two event bits are not built here
  localparam logic [EVT_W-1:0] IMPL_MASK = 8'h3F;
  localparam logic [EVT_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [EVT_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rim_pkg

// ==== rtl/rim_sync.sv ====
`timescale 1ns/1ps
module rim_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // async event levels and synchronised result
  input wire logic [rim_pkg::EVT_W-1:0] asyncIn,
  output logic [rim_pkg::EVT_W-1:0] syncOut
);
  logic [rim_pkg::EVT_W-1:0] stage1Q;
  logic [rim_pkg::EVT_W-1:0] stage2Q;
  logic [rim_pkg::EVT_W-1:0] stage3Q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1Q <= '0;
      stage2Q <= '0;
      stage3Q <= '0;
    end else begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
    end
  end

  // rising edge taken between second and third stage only
  assign syncOut = stage2Q & ~stage3Q;
endmodule : rim_sync

// ==== rtl/rim_top.sv ====
// Overview of operation
// - enable bit 5 passes the receive timeout event to the interrupt; resets 0.
// - enable bit 4 passes packet complete or under/overflow event; resets 0.
// - enable bit 2 passes the preamble quality threshold event; resets 0.
// - enable bit 0 passes the sync word found event; resets 0.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rim_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // radio event levels, asynchronous to clk_sys
  input wire logic [rim_pkg::EVT_W-1:0] radioEvent,
  // interrupt
  output logic irq,
  // axi4-lite write address
  input wire logic [rim_pkg::ADDR_W+1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [rim_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [rim_pkg::ADDR_W+1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [rim_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [rim_pkg::EVT_W-1:0] radio_event_enable_q;
  logic [rim_pkg::EVT_W-1:0] radio_event_enable_d;
  logic [rim_pkg::EVT_W-1:0] pendQ;
  wire [rim_pkg::EVT_W-1:0] pendD;
  logic [rim_pkg::EVT_W-1:0] evtPulse;
  logic awHeldQ;
  logic wHeldQ;
  logic [rim_pkg::ADDR_W+1:0] awAddrQ;
  logic [rim_pkg::EVT_W-1:0] wDataQ;
  logic wLane0Q;
  logic bValidQ;
  logic [1:0] bRespQ;
  logic rValidQ;
  logic [1:0] rRespQ;
  logic [rim_pkg::DATA_W-1:0] rDataQ;

  rim_sync u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn(radioEvent),
    .syncOut(evtPulse)
  );

  // write path: address and data are caught in either order
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeldQ && wHeldQ && !bValidQ;
  wire wrEnable = doWrite && awAddrQ == rim_pkg::ENABLE_ADDR;
  wire wrStatus = doWrite && awAddrQ == rim_pkg::STATUS_ADDR;
  wire wrHit = wrEnable || wrStatus;
  wire [rim_pkg::EVT_W-1:0] wrBits = wLane0Q ? (wDataQ & rim_pkg::IMPL_MASK) : '0;
  assign s_axi_awready = !awHeldQ && !bValidQ;
  assign s_axi_wready = !wHeldQ && !bValidQ;
  assign s_axi_bvalid = bValidQ;
  assign s_axi_bresp = bRespQ;

  // read path
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rdEnable = s_axi_araddr == rim_pkg::ENABLE_ADDR;
  wire rdStatus = s_axi_araddr == rim_pkg::STATUS_ADDR;
  wire [rim_pkg::EVT_W-1:0] rdBits = rdEnable ? radio_event_enable_q :
                                     rdStatus ? pendQ : '0;
  assign s_axi_arready = !rValidQ;
  assign s_axi_rvalid = rValidQ;
  assign s_axi_rresp = rRespQ;
  assign s_axi_rdata = rDataQ;

  // each enable bit is one event gate
  assign radio_event_enable_d = wrEnable ? wrBits : radio_event_enable_q;

  // write-one clears, but a new event in the same cycle wins
  wire [rim_pkg::EVT_W-1:0] clrBits = wrStatus ? wrBits : '0;
  wire [rim_pkg::EVT_W-1:0] gated;

  // one pending flag and one gate per event bit
  for (genvar i = 0; i < rim_pkg::EVT_W; i++) begin : g_evt
    // bits 7:6 stay tied off so software never sees a flag it cannot mask
    assign pendD[i] = rim_pkg::IMPL_MASK[i] && ((pendQ[i] && !clrBits[i]) || evtPulse[i]);
    assign gated[i] = pendQ[i] && radio_event_enable_q[i];

    a_bit_sets: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (rim_pkg::IMPL_MASK[i] && evtPulse[i]) |=> pendQ[i])
      else $error("event bit not latched");
    a_bit_clears: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (clrBits[i] && !evtPulse[i]) |=> !pendQ[i])
      else $error("event bit not cleared");
    a_bit_holds: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (!clrBits[i] && !evtPulse[i]) |=> (pendQ[i] == $past(pendQ[i])))
      else $error("event bit changed alone");
    a_bit_reaches: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (pendQ[i] && radio_event_enable_q[i]) |-> irq)
      else $error("enabled bit not on line");
  end

  // gating of pending events onto the line
  assign irq = |gated;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      radio_event_enable_q <= rim_pkg::ENABLE_RESET;
      pendQ <= rim_pkg::STATUS_RESET;
    end else begin
      radio_event_enable_q <= radio_event_enable_d;
      pendQ <= pendD;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end else if (awTake) begin
      awHeldQ <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wLane0Q <= 1'b0;
    end else if (wTake) begin
      wHeldQ <= 1'b1;
      wDataQ <= s_axi_wdata[rim_pkg::EVT_W-1:0];
      wLane0Q <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bValidQ <= 1'b0;
      bRespQ <= rim_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bValidQ <= 1'b1;
      bRespQ <= wrHit ? rim_pkg::RESP_OKAY : rim_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValidQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rValidQ <= 1'b0;
      rRespQ <= rim_pkg::RESP_OKAY;
      rDataQ <= '0;
    end else if (arTake) begin
      rValidQ <= 1'b1;
      rRespQ <= (rdEnable || rdStatus) ? rim_pkg::RESP_OKAY : rim_pkg::RESP_SLVERR;
      rDataQ <= {{(rim_pkg::DATA_W-rim_pkg::EVT_W){1'b0}}, rdBits};
    end else if (s_axi_rready) begin
      rValidQ <= 1'b0;
    end
  end

  // checks: each enabled bit reaches the line
  a_timeout_gate: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (pendQ[rim_pkg::BIT_TIMEOUT] && radio_event_enable_q[rim_pkg::BIT_TIMEOUT]) |-> irq)
    else $error("timeout not raised");
  a_done_gate: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (pendQ[rim_pkg::BIT_DONE] && radio_event_enable_q[rim_pkg::BIT_DONE]) |-> irq)
    else $error("done not raised");
  a_pqt_gate: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (pendQ[rim_pkg::BIT_PQT] && radio_event_enable_q[rim_pkg::BIT_PQT]) |-> irq)
    else $error("preamble not raised");
  a_sync_gate: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (pendQ[rim_pkg::BIT_SFD] && radio_event_enable_q[rim_pkg::BIT_SFD]) |-> irq)
    else $error("sync not raised");
  a_cs_cca_gate: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ((pendQ[rim_pkg::BIT_CS] && radio_event_enable_q[rim_pkg::BIT_CS]) ||
     (pendQ[rim_pkg::BIT_CCA] && radio_event_enable_q[rim_pkg::BIT_CCA])) |-> irq)
    else $error("cs or cca not raised");

  // a cleared enable bit keeps its event off the line
  a_timeout_blocked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !radio_event_enable_q[rim_pkg::BIT_TIMEOUT] |-> !gated[rim_pkg::BIT_TIMEOUT])
    else $error("blocked timeout passed");
  a_done_blocked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !radio_event_enable_q[rim_pkg::BIT_DONE] |-> !gated[rim_pkg::BIT_DONE])
    else $error("blocked done passed");
  a_pqt_blocked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !radio_event_enable_q[rim_pkg::BIT_PQT] |-> !gated[rim_pkg::BIT_PQT])
    else $error("blocked preamble passed");
  a_sync_blocked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !radio_event_enable_q[rim_pkg::BIT_SFD] |-> !gated[rim_pkg::BIT_SFD])
    else $error("blocked sync passed");
  a_cs_cca_blocked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (!radio_event_enable_q[rim_pkg::BIT_CS] |-> !gated[rim_pkg::BIT_CS]) and
    (!radio_event_enable_q[rim_pkg::BIT_CCA] |-> !gated[rim_pkg::BIT_CCA]))
    else $error("blocked cs or cca passed");

  // register behaviour
  a_masked_quiet: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (radio_event_enable_q == '0) |-> !irq)
    else $error("irq with all disabled");
  a_enable_write: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    wrEnable |=> radio_event_enable_q == $past(wrBits))
    else $error("enable write lost");
  a_event_sticks: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (evtPulse[rim_pkg::BIT_DONE]) |=> pendQ[rim_pkg::BIT_DONE])
    else $error("event lost");
  a_enable_reset: assert property (
    @(posedge clk_sys)
    !arst_n |-> (radio_event_enable_q == rim_pkg::ENABLE_RESET && !irq))
    else $error("enable not cleared by reset");
  a_enable_holds: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !wrEnable |=> radio_event_enable_q == $past(radio_event_enable_q))
    else $error("enable changed without write");
  a_upper_quiet: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ((radio_event_enable_q & ~rim_pkg::IMPL_MASK) == '0) &&
    ((pendQ & ~rim_pkg::IMPL_MASK) == '0))
    else $error("unbuilt bit set");
  a_irq_source: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    irq |-> ((pendQ & radio_event_enable_q) != '0))
    else $error("irq without enabled event");
  a_read_enable: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (arTake && rdEnable) |=> (rDataQ[rim_pkg::EVT_W-1:0] == $past(radio_event_enable_q)
      && rDataQ[rim_pkg::DATA_W-1:rim_pkg::EVT_W] == '0))
    else $error("enable readback wrong");

  // bus behaviour
  a_write_resp: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    doWrite |=> bValidQ)
    else $error("no write response");
  a_write_single: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    doWrite |=> !doWrite)
    else $error("write applied twice");
  a_unmapped_err: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (doWrite && !wrHit) |=> (bRespQ == rim_pkg::RESP_SLVERR
      && radio_event_enable_q == $past(radio_event_enable_q)))
    else $error("unmapped write not refused");
  a_bvalid_holds: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (bValidQ && !s_axi_bready) |=> (bValidQ && $stable(bRespQ)))
    else $error("write response dropped");
  a_busy_refuse: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    bValidQ |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while busy");
  a_read_resp: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    arTake |=> rValidQ)
    else $error("no read response");
  a_rvalid_holds: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (rValidQ && !s_axi_rready) |=> (rValidQ && $stable(rDataQ)
      && $stable(rRespQ)))
    else $error("read response dropped");
  a_read_refuse: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rValidQ |-> !s_axi_arready)
    else $error("read taken while busy");

  // main scenarios
  c_irq_rise: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(irq));
  c_clear_race: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wrStatus && (evtPulse & wrBits) != '0);
  c_read_status: cover property (@(posedge clk_sys) disable iff (!arst_n) arTake && rdStatus);
  c_write_error: cover property (@(posedge clk_sys) disable iff (!arst_n) doWrite && !wrHit);
  c_all_enabled: cover property (@(posedge clk_sys) disable iff (!arst_n)
    (radio_event_enable_q & rim_pkg::IMPL_MASK) == rim_pkg::IMPL_MASK);
endmodule : rim_top

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] radioEvent = 8'h00;
  logic irq, awReady, wReady, bValid, arReady, rValid;
  logic [9:0] awAddr = 10'h000;
  logic [9:0] arAddr = 10'h000;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h0, rData;
  logic [1:0] bResp, rResp;
  int err_count = 0;
  int comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  rim_top rim_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .radioEvent(radioEvent), .irq(irq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  // ready and valid are sampled at the negedge, so they equal what the next edge sees
  task automatic bus(input logic rd, input logic [9:0] a, input logic [7:0] v,
      output logic [31:0] d, output logic [1:0] r);
    logic aR, wR, ans;
    bit done;
    @(posedge clk_sys);
    if (rd) begin
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
    end else begin
      awAddr <= a;
      wData <= {24'h0, v};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
    end
    done = 1'b0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk_sys);
      aR = rd ? arReady : awReady;
      wR = wReady;
      ans = rd ? rValid : bValid;
      d = rData;
      r = rd ? rResp : bResp;
      @(posedge clk_sys);
      if (aR) arValid <= 1'b0;
      if (aR && !rd) awValid <= 1'b0;
      if (wR) wValid <= 1'b0;
      if (ans) begin
        rReady <= 1'b0;
        bReady <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      err_count++;
      wrap_up();
    end
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic [1:0] r;
    bus(1'b0, a, v, d, r);
  endtask : wr
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] want);
    logic [31:0] d;
    logic [1:0] r;
    bus(1'b1, a, 8'h00, d, r);
    chk(d, want);
  endtask : rd_chk
  task automatic test_reset;
    rd_chk(rim_pkg::ENABLE_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_readback;
    wr(rim_pkg::ENABLE_ADDR, 8'hFF);
    rd_chk(rim_pkg::ENABLE_ADDR, 32'h3F);
    wr(rim_pkg::ENABLE_ADDR, 8'h15);
    rd_chk(rim_pkg::ENABLE_ADDR, 32'h15);
    wr(rim_pkg::ENABLE_ADDR, 8'h2A);
    rd_chk(rim_pkg::ENABLE_ADDR, 32'h2A);
    $display("test_readback done");
  endtask : test_readback
  // each event alone, first blocked by its own bit with all others open, then passed
  task automatic test_gate;
    logic [7:0] m;
    for (int b = 0; b < 6; b++) begin
      m = 8'h01 << b;
      wr(rim_pkg::ENABLE_ADDR, ~m & 8'h3F);
      radioEvent <= m;
      repeat (6) @(posedge clk_sys);
      radioEvent <= 8'h00;
      #1 chk({31'h0, irq}, 32'h0);
      rd_chk(rim_pkg::STATUS_ADDR, {24'h0, m});
      wr(rim_pkg::ENABLE_ADDR, m);
      #1 chk({31'h0, irq}, 32'h1);
      wr(rim_pkg::STATUS_ADDR, m);
      #1 chk({31'h0, irq}, 32'h0);
    end
    $display("test_gate done");
  endtask : test_gate
  task automatic test_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    bus(1'b0, 10'h000, 8'h3F, d, r);
    chk({30'h0, r}, {30'h0, rim_pkg::RESP_SLVERR});
    bus(1'b1, 10'h000, 8'h00, d, r);
    chk({30'h0, r}, {30'h0, rim_pkg::RESP_SLVERR});
    rd_chk(rim_pkg::ENABLE_ADDR, 32'h20);
    $display("test_unmapped done");
  endtask : test_unmapped
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_reset();
    test_readback();
    test_gate();
    test_unmapped();
    wrap_up();
  end
endmodule : testbench
